/* rtl/omsc_pkg.sv */
package omsc_pkg;

  // Register bus geometry: each register takes one aligned 32-bit word.
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // Printed register indices; the byte address is four times the index.
  localparam logic [15:0] MODE_READBACK_IDX = 16'hfff1;
  localparam logic [15:0] SYSTEM_CONTROL_IDX = 16'hfff2;
  localparam logic [ADDR_W-1:0] MODE_READBACK_ADR = {MODE_READBACK_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] SYSTEM_CONTROL_ADR = {SYSTEM_CONTROL_IDX, 2'b00};

  // Mode readback layout: fixed ones on top, fixed zeros in the middle.
  localparam logic [1:0] MODE_RB_ONES = 2'h3;
  localparam logic [2:0] MODE_RB_ZEROS = 3'h0;

  // System control field positions and reset value.
  localparam int SC_STANDBY_BIT = 7;
  localparam int SC_SETTLE_HI = 6;
  localparam int SC_SETTLE_LO = 4;
  localparam int SC_USER_EN_BIT = 3;
  localparam int SC_NMI_EDGE_BIT = 2;
  localparam int SC_RESERVED_BIT = 1;
  localparam int SC_RAM_ON_BIT = 0;
  localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h0b;

  // Mode-select pin codes.
  localparam logic [2:0] MODE1_CODE = 3'h1;
  localparam logic [2:0] MODE3_CODE = 3'h3;
  localparam logic [2:0] MODE5_CODE = 3'h5;
  localparam logic [2:0] MODE6_CODE = 3'h6;
  localparam logic [2:0] MODE7_CODE = 3'h7;

  // Address bus widths of the three address space sizes.
  localparam logic [4:0] SPACE_64K_BITS = 5'h10;
  localparam logic [4:0] SPACE_1M_BITS = 5'h14;
  localparam logic [4:0] SPACE_16M_BITS = 5'h18;

  // Oscillator settle waits in states (system clock cycles).
  localparam int SETTLE_W = 18;
  localparam logic [SETTLE_W-1:0] SETTLE_CODE0_STATES = 18'h02000;
  localparam logic [SETTLE_W-1:0] SETTLE_CODE1_STATES = 18'h04000;
  localparam logic [SETTLE_W-1:0] SETTLE_CODE2_STATES = 18'h08000;
  localparam logic [SETTLE_W-1:0] SETTLE_CODE3_STATES = 18'h10000;
  localparam logic [SETTLE_W-1:0] SETTLE_CODE4_STATES = 18'h20000;
  localparam logic [SETTLE_W-1:0] SETTLE_CODE5_STATES = 18'h00400;

  // Operating mode classes.
  typedef enum logic [2:0] {
    OMSC_MODE_EXP_1M_NOROM,
    OMSC_MODE_EXP_16M_NOROM,
    OMSC_MODE_EXP_1M_ROM,
    OMSC_MODE_SINGLE_64K,
    OMSC_MODE_SINGLE_1M,
    OMSC_MODE_UNSUPPORTED
  } omsc_mode_e;

endpackage

/* rtl/omsc_top.sv */
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps

module omsc_top #(
  parameter logic [omsc_pkg::SETTLE_W-1:0] SETTLE_CODE0 = omsc_pkg::SETTLE_CODE0_STATES, // Code 000 wait.
  parameter logic [omsc_pkg::SETTLE_W-1:0] SETTLE_CODE1 = omsc_pkg::SETTLE_CODE1_STATES, // Code 001 wait.
  parameter logic [omsc_pkg::SETTLE_W-1:0] SETTLE_CODE2 = omsc_pkg::SETTLE_CODE2_STATES, // Code 010 wait.
  parameter logic [omsc_pkg::SETTLE_W-1:0] SETTLE_CODE3 = omsc_pkg::SETTLE_CODE3_STATES, // Code 011 wait.
  parameter logic [omsc_pkg::SETTLE_W-1:0] SETTLE_CODE4 = omsc_pkg::SETTLE_CODE4_STATES  // Code 100 wait.
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Classic Wishbone slave.
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [omsc_pkg::ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [omsc_pkg::DATA_W-1:0] wb_dat_in,
  output logic [omsc_pkg::DATA_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // Mode straps.
  input wire logic [2:0] mode_select_pins_in,
  // Decoded mode.
  output logic mode_error_out,
  output logic expanded_mode_out,
  output logic single_chip_out,
  output logic onchip_rom_on_out,
  output logic [4:0] addr_bits_out,
  output logic init_bus_8bit_out,
  // Control fields seen by the rest of the chip.
  output logic standby_select_out,
  output logic [2:0] settle_wait_select_out,
  output logic user_flag_is_mask_out,
  output logic nmi_edge_select_out,
  output logic onchip_ram_on_out,
  // Halt instruction and power-down requests.
  input wire logic halt_instr_in,
  output logic enter_sleep_out,
  output logic enter_standby_out,
  // Standby exit by external interrupt and oscillator settle timer.
  input wire logic standby_exit_irq_in,
  output logic settle_busy_out,
  output logic settle_done_out,
  output logic settle_code_illegal_out,
  // NMI edge detection.
  input wire logic nmi_in,
  output logic nmi_request_out,
  // Exception entry effects on the condition flags.
  input wire logic exception_entry_in,
  output logic set_irq_mask_out,
  output logic set_ccr_user_flag_out,
  // On-chip RAM region access path.
  input wire logic ram_region_hit_in,
  input wire logic ram_write_in,
  input wire logic [7:0] ram_rdata_in,
  output logic ram_select_out,
  output logic ram_external_out,
  output logic ram_write_en_out,
  output logic [7:0] ram_rdata_out
);
  import omsc_pkg::*;

  logic [7:0] sysctl_r; // System control register storage.
  logic [7:0] sysctl_nxt; // Next value of the control register on a write.
  logic ack_r; // Registered bus acknowledge.
  logic [DATA_W-1:0] dat_r; // Registered read data.
  logic bus_req; // A new bus request is waiting.
  logic sel_mode; // Request addresses the mode readback register.
  logic sel_sys; // Request addresses the system control register.
  omsc_mode_e mode_cls; // Combinational class of the strap code.
  logic nmi_prev_r; // NMI level one cycle ago.
  logic [SETTLE_W-1:0] settle_cnt_r; // Remaining settle states.
  logic [SETTLE_W-1:0] settle_len; // Wait length for the current code.

  // A request is taken once; ack drops in the cycle after it was given.
  assign bus_req = wb_cyc_in && wb_stb_in && !ack_r;
  assign sel_mode = (wb_adr_in == MODE_READBACK_ADR);
  assign sel_sys = (wb_adr_in == SYSTEM_CONTROL_ADR);
  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;

  // Strap decode into a mode class.
  always_comb begin
    unique case (mode_select_pins_in)
      MODE1_CODE: mode_cls = OMSC_MODE_EXP_1M_NOROM;
      MODE3_CODE: mode_cls = OMSC_MODE_EXP_16M_NOROM;
      MODE5_CODE: mode_cls = OMSC_MODE_EXP_1M_ROM;
      MODE6_CODE: mode_cls = OMSC_MODE_SINGLE_64K;
      MODE7_CODE: mode_cls = OMSC_MODE_SINGLE_1M;
      default: mode_cls = OMSC_MODE_UNSUPPORTED; // Codes 000, 010 and 100.
    endcase
  end

  // Registered mode outputs; the straps are assumed constant in use.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mode_error_out <= 1'b0;
      expanded_mode_out <= 1'b0;
      single_chip_out <= 1'b0;
      onchip_rom_on_out <= 1'b0;
      addr_bits_out <= 5'h00;
    end else begin
      mode_error_out <= 1'b0;
      expanded_mode_out <= 1'b0;
      single_chip_out <= 1'b0;
      onchip_rom_on_out <= 1'b0;
      addr_bits_out <= SPACE_1M_BITS;
      unique case (mode_cls)
        OMSC_MODE_EXP_1M_NOROM: begin
          expanded_mode_out <= 1'b1;
        end
        OMSC_MODE_EXP_16M_NOROM: begin
          expanded_mode_out <= 1'b1;
          addr_bits_out <= SPACE_16M_BITS;
        end
        OMSC_MODE_EXP_1M_ROM: begin
          expanded_mode_out <= 1'b1;
          onchip_rom_on_out <= 1'b1;
        end
        OMSC_MODE_SINGLE_64K: begin
          single_chip_out <= 1'b1;
          onchip_rom_on_out <= 1'b1;
          addr_bits_out <= SPACE_64K_BITS;
        end
        OMSC_MODE_SINGLE_1M: begin
          single_chip_out <= 1'b1;
          onchip_rom_on_out <= 1'b1;
        end
        OMSC_MODE_UNSUPPORTED: begin
          mode_error_out <= 1'b1;
          addr_bits_out <= 5'h00;
        end
      endcase
    end
  end

  // Expanded modes come out of reset with an 8-bit bus on every area.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      init_bus_8bit_out <= 1'b0;
    end else begin
      init_bus_8bit_out <= (mode_cls == OMSC_MODE_EXP_1M_NOROM) ||
                           (mode_cls == OMSC_MODE_EXP_16M_NOROM) ||
                           (mode_cls == OMSC_MODE_EXP_1M_ROM);
    end
  end

  // Next control value: byte lane 0 writes, the reserved bit stays one.
  always_comb begin
    sysctl_nxt = wb_dat_in[7:0];
    sysctl_nxt[SC_RESERVED_BIT] = 1'b1;
  end

  // Control register; only reset and software writes change it.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sysctl_r <= SYSTEM_CONTROL_RESET;
    end else if (bus_req && wb_we_in && sel_sys && wb_sel_in[0]) begin
      sysctl_r <= sysctl_nxt;
    end
  end

  // Bus answer: one wait state, read data captured with the pins.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_in) begin
        if (sel_mode) begin
          dat_r <= {24'h000000, MODE_RB_ONES, MODE_RB_ZEROS, mode_select_pins_in};
        end else if (sel_sys) begin
          dat_r <= {24'h000000, sysctl_r};
        end else begin
          dat_r <= '0; // Unmapped addresses read zero.
        end
      end
    end
  end

  // Control fields as plain levels.
  assign standby_select_out = sysctl_r[SC_STANDBY_BIT];
  assign settle_wait_select_out = sysctl_r[SC_SETTLE_HI:SC_SETTLE_LO];
  assign user_flag_is_mask_out = !sysctl_r[SC_USER_EN_BIT];
  assign nmi_edge_select_out = sysctl_r[SC_NMI_EDGE_BIT];
  assign onchip_ram_on_out = sysctl_r[SC_RAM_ON_BIT];

  // Halt instruction picks sleep or software standby.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      enter_sleep_out <= 1'b0;
      enter_standby_out <= 1'b0;
    end else begin
      enter_sleep_out <= halt_instr_in && !sysctl_r[SC_STANDBY_BIT];
      enter_standby_out <= halt_instr_in && sysctl_r[SC_STANDBY_BIT];
    end
  end

  // Settle length per code; illegal codes take the code 100 wait.
  always_comb begin
    unique case (sysctl_r[SC_SETTLE_HI:SC_SETTLE_LO])
      3'h0: settle_len = SETTLE_CODE0;
      3'h1: settle_len = SETTLE_CODE1;
      3'h2: settle_len = SETTLE_CODE2;
      3'h3: settle_len = SETTLE_CODE3;
      3'h4: settle_len = SETTLE_CODE4;
      3'h5: settle_len = SETTLE_CODE5_STATES;
      default: settle_len = SETTLE_CODE4;
    endcase
  end

  assign settle_code_illegal_out = (sysctl_r[SC_SETTLE_HI:SC_SETTLE_LO] >= 3'h6);
  assign settle_busy_out = (settle_cnt_r != '0);

  // Settle timer: counts the wait down after an interrupt exit.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      settle_cnt_r <= '0;
      settle_done_out <= 1'b0;
    end else begin
      settle_done_out <= (settle_cnt_r == {{(SETTLE_W-1){1'b0}}, 1'b1});
      if (standby_exit_irq_in && settle_cnt_r == '0) begin
        settle_cnt_r <= settle_len;
      end else if (settle_cnt_r != '0) begin
        settle_cnt_r <= settle_cnt_r - {{(SETTLE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // NMI edge detection on the selected edge.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      nmi_prev_r <= 1'b1;
      nmi_request_out <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_in;
      if (sysctl_r[SC_NMI_EDGE_BIT]) begin
        nmi_request_out <= nmi_in && !nmi_prev_r;
      end else begin
        nmi_request_out <= !nmi_in && nmi_prev_r;
      end
    end
  end

  // Exception entry always masks, and sets the user flag when it is a mask.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      set_irq_mask_out <= 1'b0;
      set_ccr_user_flag_out <= 1'b0;
    end else begin
      set_irq_mask_out <= exception_entry_in;
      set_ccr_user_flag_out <= exception_entry_in && !sysctl_r[SC_USER_EN_BIT];
    end
  end

  // On-chip RAM region steering; disabled RAM goes external or blank.
  always_comb begin
    ram_select_out = ram_region_hit_in && sysctl_r[SC_RAM_ON_BIT];
    ram_external_out = ram_region_hit_in && !sysctl_r[SC_RAM_ON_BIT] && expanded_mode_out;
    ram_write_en_out = ram_select_out && ram_write_in;
    if (ram_region_hit_in && !sysctl_r[SC_RAM_ON_BIT] && single_chip_out) begin
      ram_rdata_out = 8'hff;
    end else begin
      ram_rdata_out = ram_rdata_in;
    end
  end

  default clocking omsc_cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Reset always leaves the control register at its reset value.
  sysctl_reset_a: assert property (disable iff (1'b0) !rst_n_in |=> sysctl_r == 8'h0b)
    else $error("control register not at reset value");

  // Mode readback shape and pin sample.
  mode_read_a: assert property (bus_req && !wb_we_in && sel_mode |=>
      wb_ack_out && wb_dat_out == {24'h000000, 5'b11000, $past(mode_select_pins_in)})
    else $error("mode readback wrong");

  // Reserved bit reads one on a control read, even after writing zero.
  resvd_bit_a: assert property (bus_req && !wb_we_in && sel_sys |=>
      wb_ack_out && wb_dat_out[1] && wb_dat_out[31:8] == 24'h000000)
    else $error("reserved control bit not one");

  // Standby select holds unless software writes the register.
  standby_hold_a: assert property (sysctl_r[7] && !(bus_req && wb_we_in && sel_sys) |=> sysctl_r[7])
    else $error("standby select lost");

  // RAM enable changes only by reset or write.
  ram_on_hold_a: assert property ($changed(sysctl_r[0]) |-> $past(bus_req && wb_we_in && sel_sys) || $past(!rst_n_in))
    else $error("RAM enable changed by itself");

  // Halt goes to exactly one of the two power-down requests.
  halt_select_a: assert property (halt_instr_in |=>
      enter_standby_out == $past(sysctl_r[7]) && enter_sleep_out == !$past(sysctl_r[7]))
    else $error("halt request wrong");

  // Short settle code starts a 1024-state wait.
  settle_len_a: assert property (standby_exit_irq_in && !settle_busy_out && sysctl_r[6:4] == 3'h5 |=>
      settle_cnt_r == 18'h00400 ##1 settle_busy_out)
    else $error("settle wait length wrong");

  // Falling NMI edge requests when edge select is zero.
  nmi_fall_a: assert property (!sysctl_r[2] && $fell(nmi_in) |=> nmi_request_out)
    else $error("falling NMI edge missed");

  // Exception entry effects.
  except_a: assert property (exception_entry_in |=>
      set_irq_mask_out && set_ccr_user_flag_out == !$past(sysctl_r[3]))
    else $error("exception entry effects wrong");

  // Single-chip disabled RAM reads FF and blocks writes.
  ram_blank_a: assert property (single_chip_out && !sysctl_r[0] && ram_region_hit_in |->
      ram_rdata_out == 8'hff && !ram_write_en_out)
    else $error("disabled RAM not blank");

  // Expanded disabled RAM goes external.
  ram_ext_a: assert property (expanded_mode_out && !sysctl_r[0] && ram_region_hit_in |->
      ram_external_out && !ram_select_out)
    else $error("RAM region not external");

  // Mode 3 decode.
  mode3_dec_a: assert property (mode_select_pins_in == 3'h3 |=>
      expanded_mode_out && !onchip_rom_on_out && addr_bits_out == 5'h18)
    else $error("mode 3 decode wrong");

  // Mode 6 decode.
  mode6_dec_a: assert property (mode_select_pins_in == 3'h6 |=>
      single_chip_out && onchip_rom_on_out && addr_bits_out == 5'h10)
    else $error("mode 6 decode wrong");

  // Unsupported codes flag an error.
  mode_err_a: assert property (mode_select_pins_in inside {3'h0, 3'h2, 3'h4} |=> mode_error_out)
    else $error("unsupported mode not flagged");

  // Rising NMI edge requests when edge select is one.
  nmi_rise_a: assert property (sysctl_r[SC_NMI_EDGE_BIT] && $rose(nmi_in) |=> nmi_request_out)
    else $error("rising NMI edge missed");

  // A finished settle wait gives one done pulse as the busy level falls.
  settle_done_a: assert property ($fell(settle_busy_out) && $past(rst_n_in) |-> settle_done_out)
    else $error("settle done pulse missing");

  // Writes into the RAM region pass only while the RAM is on.
  ram_write_a: assert property (ram_write_en_out |-> sysctl_r[SC_RAM_ON_BIT] && ram_region_hit_in && ram_write_in)
    else $error("RAM write while disabled");

endmodule

/* testbench/omsc_board_model.sv */
`timescale 1ns/10ps

// Board straps and the on-chip RAM array as seen from the control block.
module omsc_board_model (
  input wire logic mclk_in,
  input wire logic [2:0] strap_code_in,
  input wire logic ram_select_in,
  output logic [2:0] mode_select_pins_out,
  output logic [7:0] ram_rdata_out
);
  // Straps are resistors: the pins take the chosen code and hold it.
  assign mode_select_pins_out = strap_code_in;
  // A deselected array keeps nothing on its lines; it toggles every cycle.
  logic [7:0] junk_r = 8'h00;
  always_ff @(posedge mclk_in) begin
    junk_r <= ~junk_r;
  end
  // The stored byte is a fixed pattern while the array is selected.
  assign ram_rdata_out = ram_select_in ? 8'h5a : junk_r;
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps

// Self-checking bench for the operating mode and system control block.
module tb_top;
  import omsc_pkg::*;

  logic mclk_in = 1'b0, rst_n_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, nmi = 1'b1, hit = 1'b0, rwr = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0, rdat;
  logic [3:0] sel = 4'h1;
  logic [2:0] strap = 3'h7, pins, sws, pin = 3'h0; // Pulse inputs: halt, standby exit, exception.
  logic [7:0] ram_q, ram_d, q;
  logic [4:0] abits;
  logic ack, merr, expm, single, rom, bus8, sby, ufm, nedge, ram_on, slp, stby, busy, done, ill, nreq, smask, suf;
  logic rsel, rext, rwe;
  int bad_count = 0;
  int n_tests = 0;

  // Short settle waits keep the run brief; code 5 has its fixed wait.
  omsc_top #(.SETTLE_CODE0(18'h10), .SETTLE_CODE1(18'h20), .SETTLE_CODE2(18'h30), .SETTLE_CODE3(18'h40),
    .SETTLE_CODE4(18'h50)) i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .mode_select_pins_in(pins), .mode_error_out(merr), .expanded_mode_out(expm), .single_chip_out(single),
    .onchip_rom_on_out(rom), .addr_bits_out(abits), .init_bus_8bit_out(bus8), .standby_select_out(sby),
    .settle_wait_select_out(sws), .user_flag_is_mask_out(ufm), .nmi_edge_select_out(nedge),
    .onchip_ram_on_out(ram_on), .halt_instr_in(pin[0]), .enter_sleep_out(slp), .enter_standby_out(stby),
    .standby_exit_irq_in(pin[1]), .settle_busy_out(busy), .settle_done_out(done),
    .settle_code_illegal_out(ill), .nmi_in(nmi), .nmi_request_out(nreq), .exception_entry_in(pin[2]),
    .set_irq_mask_out(smask), .set_ccr_user_flag_out(suf), .ram_region_hit_in(hit), .ram_write_in(rwr),
    .ram_rdata_in(ram_q), .ram_select_out(rsel), .ram_external_out(rext), .ram_write_en_out(rwe),
    .ram_rdata_out(ram_d));

  omsc_board_model i_board (.mclk_in(mclk_in), .strap_code_in(strap), .ram_select_in(rsel),
    .mode_select_pins_out(pins), .ram_rdata_out(ram_q));

  // Clock at 40 MHz.
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Counts every compare and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // One classic Wishbone cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge mclk_in); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Raises one pulse input for a single edge, then lets its registered answer settle.
  task automatic pulse(input int i);
    @(posedge mclk_in);
    pin[i] <= 1'b1;
    @(posedge mclk_in);
    pin[i] <= 1'b0;
    #1;
  endtask

  // Moves the NMI line and counts request pulses over the following cycles.
  task automatic nmi_to(input logic v, input int exp);
    int n;
    n = 0;
    @(posedge mclk_in);
    nmi <= v;
    repeat (4) begin
      @(posedge mclk_in);
      #1;
      n += int'(nreq === 1'b1);
    end
    chk("nmi requests", n, exp);
  endtask

  // Reset values of the control register and its fields.
  task automatic t_reset;
    wb(1'b0, SYSTEM_CONTROL_ADR, 8'h00, q);
    chk("control reset", q, 8'h0b);
    chk("control fields", {sby, sws, ufm, nedge, ram_on}, 7'h01);
    $display("test reset done");
  endtask

  // Every strap code: decode, error flag and readback with write attempts.
  task automatic t_modes;
    logic [8:0] exp;
    for (int c = 0; c < 8; c++) begin
      strap <= 3'(c);
      repeat (3) @(posedge mclk_in);
      #1;
      chk("mode error", merr, (c == 0 || c == 2 || c == 4));
      case (c)
        0, 2, 4: exp = 9'h000;
        1: exp = {4'b1001, SPACE_1M_BITS};
        3: exp = {4'b1001, SPACE_16M_BITS};
        5: exp = {4'b1011, SPACE_1M_BITS};
        6: exp = {4'b0110, SPACE_64K_BITS};
        default: exp = {4'b0110, SPACE_1M_BITS};
      endcase
      chk("mode decode", {expm, single, rom, bus8, abits}, exp);
      wb(1'b0, MODE_READBACK_ADR, 8'h00, q);
      chk("readback", q, 8'hc0 | 8'(c));
      wb(1'b1, MODE_READBACK_ADR, 8'h38, q);
      wb(1'b0, MODE_READBACK_ADR, 8'h00, q);
      chk("readback after write", q, 8'hc0 | 8'(c));
    end
    $display("test modes done");
  endtask

  // Field writes, the reserved bit, the illegal settle code and an unmapped place.
  task automatic t_control;
    wb(1'b1, SYSTEM_CONTROL_ADR, 8'h74, q);
    wb(1'b0, SYSTEM_CONTROL_ADR, 8'h00, q);
    chk("control read", q, 8'h76);
    chk("control fields", {sby, sws, ufm, nedge, ram_on, ill}, 8'h7d);
    // A write with byte lane 0 disabled must leave the register alone.
    sel <= 4'he;
    wb(1'b1, SYSTEM_CONTROL_ADR, 8'h00, q);
    sel <= 4'h1;
    wb(1'b0, SYSTEM_CONTROL_ADR, 8'h00, q);
    chk("masked write", q, 8'h76);
    wb(1'b0, SYSTEM_CONTROL_ADR + 18'h4, 8'h00, q);
    chk("unmapped read", q, 8'h00);
    $display("test control done");
  endtask

  // RAM region with the enable off in single-chip and expanded modes, then on.
  task automatic t_ram;
    strap <= MODE6_CODE;
    hit <= 1'b1;
    rwr <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    chk("ram off single", {rdat[7:0] & 8'h0, ram_d, rwe}, {8'h0, 8'hff, 1'b0});
    @(posedge mclk_in);
    strap <= MODE1_CODE;
    repeat (3) @(posedge mclk_in);
    #1;
    chk("ram off expanded", {rext, rwe}, 2'b10);
    wb(1'b1, SYSTEM_CONTROL_ADR, 8'h0b, q);
    #1;
    chk("ram on", {rsel, rext, rwe, ram_d}, {3'b101, 8'h5a});
    @(posedge mclk_in);
    rwr <= 1'b0;
    hit <= 1'b0;
    $display("test ram done");
  endtask

  // Halt, exception entry and NMI edges under both settings.
  task automatic t_events;
    pulse(0);
    chk("halt sleep", {slp, stby}, 2'b10);
    pulse(2);
    chk("exception user bit", {smask, suf}, 2'b10);
    nmi_to(1'b0, 1);
    nmi_to(1'b1, 0);
    wb(1'b1, SYSTEM_CONTROL_ADR, 8'h87, q);
    pulse(0);
    chk("halt standby", {slp, stby}, 2'b01);
    pulse(2);
    chk("exception mask bit", {smask, suf}, 2'b11);
    nmi_to(1'b0, 0);
    nmi_to(1'b1, 1);
    $display("test events done");
  endtask

  // Settle wait length for every code, with standby select kept after each exit.
  task automatic t_settle;
    int n;
    int waits[8] = '{16, 32, 48, 64, 80, 1024, 80, 80};
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, SYSTEM_CONTROL_ADR, 8'h8b | 8'(c << 4), q);
      pulse(1);
      n = 0;
      while (busy === 1'b1 && n < 2000) begin
        n++;
        @(posedge mclk_in);
        #1;
      end
      chk("settle wait", n, waits[c]);
      chk("settle done", done, 1'b1);
      chk("illegal code", ill, c > 5);
      chk("standby kept", sby, 1'b1);
    end
    $display("test settle done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("compares %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_modes();
    t_control();
    t_ram();
    t_events();
    t_settle();
    report_and_stop();
  end
endmodule
